// file: logic/sphc_pkg.sv
// constants, states and carriers of the peak and hold chopper
`default_nettype none
package sphc_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 25;
    localparam int BLANK_NS      = 3000;
    localparam int BLANK_CYC     = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int PEAK_MS       = 50;
    localparam int PEAK_CYC      = PEAK_MS * CLK_MHZ * 1000;
    localparam int BLINK_HZ      = 1;
    localparam int BLINK_HALF    = (CLK_MHZ * 1000000) / (2 * BLINK_HZ);
    localparam int PWM_PERIOD_NS = 40000;
    localparam int PWM_CYC       = (PWM_PERIOD_NS * CLK_MHZ) / 1000;

    // ------------------------------------------------------------
    // reference entries
    // ------------------------------------------------------------
    localparam logic [7:0] REF_PEAK_IDX   = 8'h08;
    localparam logic [7:0] REF_HOLD_IDX   = 8'h09;
    localparam logic [7:0] REF_PEAK_RESET = 8'hda;
    localparam logic [7:0] REF_HOLD_RESET = 8'hc4;
    localparam logic [6:0] I2C_ADDR_DEF   = 7'h08; // arbitrary value

    // ------------------------------------------------------------
    // states and carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_PEAK = 2'b01,
        PH_HOLD = 2'b10
    } sphc_phase_t;

    typedef enum logic [2:0] {
        IS_IDLE  = 3'b000,
        IS_ADDR  = 3'b001,
        IS_ACKA  = 3'b010,
        IS_IDX   = 3'b011,
        IS_ACKI  = 3'b100,
        IS_DATA  = 3'b101,
        IS_ACKD  = 3'b110
    } sphc_i2c_t;

    typedef struct packed {
        logic activity;
        logic fault;
    } sphc_ind_t;
endpackage
`default_nettype wire

// file: logic/sphc_chopper.sv
// peak and hold solenoid chopper with indicators and i2c reference port
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - i2c target rewrites peak and hold references
// R2 - activity low when idle, high when active without fault
// R3 - fault blinks activity at one hertz
// R4 - fault output follows fault condition
// R5 - peak reference first, hold after delay
// R6 - one pulse steps peak to hold
// R7 - on-time forced high through blanking
// R8 - after blanking, high until comparator trips
// R9 - peak phase selects peak entry
// R10 - hold phase selects hold entry
// R11 - output energized only while command active
// R12 - two consecutive entries, peak then hold
// R13 - command low sleeps stage at once
// R14 - fault passes through a register
// R15 - each activation restarts with peak
// R16 - fixed period tick starts each blanking
module sphc_chopper #(
    parameter int         PEAK_CYC   = sphc_pkg::PEAK_CYC,
    parameter int         BLINK_HALF = sphc_pkg::BLINK_HALF,
    parameter int         PWM_CYC    = sphc_pkg::PWM_CYC,
    parameter logic [6:0] I2C_ADDR   = sphc_pkg::I2C_ADDR_DEF
) (
    input  wire logic          clk_sys_i,
    input  wire logic          resetn_i,
    input  wire logic          cmd_i,
    input  wire logic          fault_i,
    input  wire logic          trip_i,
    input  wire logic          scl_i,
    input  wire logic          sda_i,
    output logic               sda_o,
    output logic               sda_oe_n_o,
    output logic               drive_o,
    output logic               sleep_o,
    output logic [7:0]         ref_o,
    output logic               ref_sel_o,
    output logic               step_o,
    output logic               blank_o,
    output sphc_pkg::sphc_ind_t ind_o
);
    localparam int BLANK_CYC = sphc_pkg::BLANK_CYC;

    if (PEAK_CYC < 2 || BLINK_HALF < 2 || PWM_CYC <= BLANK_CYC) begin : g_chk
        $error("sphc_chopper: counts too small");
    end

    // ------------------------------------------------------------
    // reference store and i2c target
    // ------------------------------------------------------------
    function automatic logic [1:0] ref_slot(input logic [7:0] idx);
        ref_slot = {idx == sphc_pkg::REF_PEAK_IDX || idx == sphc_pkg::REF_HOLD_IDX,
                    idx == sphc_pkg::REF_HOLD_IDX};
    endfunction

    sphc_pkg::sphc_i2c_t ist_reg, ist_next;
    logic [7:0] ref_mem_reg [0:1];
    logic [7:0] ref_mem_next [0:1];
    logic [7:0] shift_reg, shift_next;
    logic [7:0] idx_reg, idx_next;
    logic [3:0] bit_reg, bit_next;
    logic       scl_q_reg, sda_q_reg;
    logic       scl_rise, scl_fall, i2c_start, i2c_stop;
    logic [1:0] slot;

    assign scl_rise  = scl_i & ~scl_q_reg;
    assign scl_fall  = ~scl_i & scl_q_reg;
    assign i2c_start = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
    assign i2c_stop  = scl_i & scl_q_reg & ~sda_q_reg & sda_i;

    always_comb begin
        ist_next        = ist_reg;
        shift_next      = shift_reg;
        idx_next        = idx_reg;
        bit_next        = bit_reg;
        ref_mem_next[0] = ref_mem_reg[0];
        ref_mem_next[1] = ref_mem_reg[1];
        slot            = ref_slot(idx_reg);
        if (i2c_start) begin
            ist_next = sphc_pkg::IS_ADDR;
            bit_next = 4'h0;
        end else if (i2c_stop) begin
            ist_next = sphc_pkg::IS_IDLE;
        end else if (scl_rise && bit_reg != 4'h8) begin
            shift_next = {shift_reg[6:0], sda_i};
            bit_next   = bit_reg + 4'h1;
        end else if (scl_fall) begin
            case (ist_reg)
                sphc_pkg::IS_ADDR: begin
                    if (bit_reg == 4'h8) begin
                        ist_next = (shift_reg == {I2C_ADDR, 1'b0}) ? sphc_pkg::IS_ACKA : sphc_pkg::IS_IDLE;
                    end
                end
                sphc_pkg::IS_IDX: begin
                    if (bit_reg == 4'h8) begin
                        idx_next = shift_reg;
                        ist_next = sphc_pkg::IS_ACKI;
                    end
                end
                sphc_pkg::IS_DATA: begin
                    if (bit_reg == 4'h8) begin
                        if (slot[1]) begin
                            ref_mem_next[slot[0]] = shift_reg; // R1 R12
                        end
                        idx_next = idx_reg + 8'h01;
                        ist_next = sphc_pkg::IS_ACKD;
                    end
                end
                sphc_pkg::IS_ACKA: begin
                    ist_next = sphc_pkg::IS_IDX;
                    bit_next = 4'h0;
                end
                sphc_pkg::IS_ACKI, sphc_pkg::IS_ACKD: begin
                    ist_next = sphc_pkg::IS_DATA;
                    bit_next = 4'h0;
                end
                default: begin
                    ist_next = sphc_pkg::IS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ist_reg        <= sphc_pkg::IS_IDLE;
            ref_mem_reg[0] <= sphc_pkg::REF_PEAK_RESET;
            ref_mem_reg[1] <= sphc_pkg::REF_HOLD_RESET;
            shift_reg      <= 8'h00;
            idx_reg        <= 8'h00;
            bit_reg        <= 4'h0;
            scl_q_reg      <= 1'b1;
            sda_q_reg      <= 1'b1;
        end else begin
            ist_reg        <= ist_next;
            ref_mem_reg[0] <= ref_mem_next[0];
            ref_mem_reg[1] <= ref_mem_next[1];
            shift_reg      <= shift_next;
            idx_reg        <= idx_next;
            bit_reg        <= bit_next;
            scl_q_reg      <= scl_i;
            sda_q_reg      <= sda_i;
        end
    end

    assign sda_o      = 1'b0;
    assign sda_oe_n_o = ~(ist_reg == sphc_pkg::IS_ACKA || ist_reg == sphc_pkg::IS_ACKI ||
                          ist_reg == sphc_pkg::IS_ACKD); // R1

    // ------------------------------------------------------------
    // peak and hold sequencing
    // ------------------------------------------------------------
    sphc_pkg::sphc_phase_t ph_reg, ph_next;
    logic [31:0] peak_reg, peak_next;
    logic        step_reg, step_next;
    logic [7:0]  ref_reg, ref_next;

    always_comb begin
        ph_next   = ph_reg;
        peak_next = peak_reg;
        step_next = 1'b0;
        case (ph_reg)
            sphc_pkg::PH_IDLE: begin
                peak_next = 32'h0;
                if (cmd_i) begin
                    ph_next = sphc_pkg::PH_PEAK; // R15
                end
            end
            sphc_pkg::PH_PEAK: begin
                peak_next = peak_reg + 32'h1;
                if (peak_reg == 32'(PEAK_CYC - 2)) begin
                    ph_next   = sphc_pkg::PH_HOLD; // R5
                    step_next = 1'b1; // R6
                end
            end
            sphc_pkg::PH_HOLD: begin
                peak_next = 32'h0;
            end
            default: begin
                ph_next = sphc_pkg::PH_IDLE;
            end
        endcase
        if (!cmd_i) begin
            ph_next   = sphc_pkg::PH_IDLE;
            step_next = 1'b0;
        end
        ref_next = (ph_next == sphc_pkg::PH_HOLD) ? ref_mem_reg[1] : ref_mem_reg[0]; // R9 R10
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ph_reg   <= sphc_pkg::PH_IDLE;
            peak_reg <= 32'h0;
            step_reg <= 1'b0;
            ref_reg  <= sphc_pkg::REF_PEAK_RESET;
        end else begin
            ph_reg   <= ph_next;
            peak_reg <= peak_next;
            step_reg <= step_next;
            ref_reg  <= ref_next;
        end
    end

    assign ref_o     = ref_reg;
    assign ref_sel_o = (ph_reg == sphc_pkg::PH_HOLD);
    assign step_o    = step_reg;

    // ------------------------------------------------------------
    // chopper
    // ------------------------------------------------------------
    logic [31:0] per_reg, per_next;
    logic [7:0]  blk_reg, blk_next;
    logic        on_reg, on_next;
    logic        tick;

    always_comb begin
        per_next = (!cmd_i || per_reg == 32'(PWM_CYC - 1)) ? 32'h0 : per_reg + 32'h1;
        tick     = cmd_i && per_reg == 32'h0; // R16
        blk_next = tick ? 8'(BLANK_CYC - 1) : ((blk_reg != 8'h00) ? blk_reg - 8'h01 : 8'h00);
        if (!cmd_i) begin
            on_next = 1'b0; // R11
        end else if (tick || blk_reg != 8'h00) begin
            on_next = 1'b1; // R7
        end else begin
            on_next = on_reg & ~trip_i; // R8
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            per_reg <= 32'h0;
            blk_reg <= 8'h00;
            on_reg  <= 1'b0;
        end else begin
            per_reg <= per_next;
            blk_reg <= blk_next;
            on_reg  <= on_next;
        end
    end

    assign drive_o = on_reg & cmd_i; // R11 R13
    assign sleep_o = ~cmd_i; // R13
    assign blank_o = on_reg & (blk_reg != 8'h00 || per_reg == 32'(BLANK_CYC)); // R7

    // ------------------------------------------------------------
    // indicators
    // ------------------------------------------------------------
    logic        flt_reg, flt_next;
    logic [31:0] blk_cnt_reg, blk_cnt_next;
    logic        blink_reg, blink_next;
    logic        act_reg, act_next;

    always_comb begin
        flt_next     = fault_i; // R14 R4
        blk_cnt_next = 32'h0;
        blink_next   = 1'b0;
        if (flt_reg) begin
            blk_cnt_next = (blk_cnt_reg == 32'(BLINK_HALF - 1)) ? 32'h0 : blk_cnt_reg + 32'h1;
            blink_next   = (blk_cnt_reg == 32'(BLINK_HALF - 1)) ? ~blink_reg : blink_reg; // R3
        end
        act_next = cmd_i & (flt_reg ? blink_next : 1'b1); // R2 R3
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flt_reg     <= 1'b0;
            blk_cnt_reg <= 32'h0;
            blink_reg   <= 1'b0;
            act_reg     <= 1'b0;
        end else begin
            flt_reg     <= flt_next;
            blk_cnt_reg <= blk_cnt_next;
            blink_reg   <= blink_next;
            act_reg     <= act_next;
        end
    end

    assign ind_o.activity = act_reg;
    assign ind_o.fault    = flt_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [31:0] on_run_reg, act_run_reg;
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            on_run_reg  <= 32'h0;
            act_run_reg <= 32'h0;
        end else begin
            on_run_reg  <= on_reg ? on_run_reg + 32'h1 : 32'h0;
            act_run_reg <= cmd_i ? act_run_reg + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    sequence s_blank_over_tripped;
        on_reg && cmd_i && blk_reg == 8'h00 && trip_i && !tick;
    endsequence

    a_sleep_on_idle: assert property (!cmd_i |-> sleep_o && !drive_o) // R13
        else $error("stage not asleep while idle");
    a_blank_min_on: assert property ($fell(on_reg) && $past(cmd_i) |-> on_run_reg >= 32'(BLANK_CYC)) // R7
        else $error("on-time shorter than blanking");
    a_trip_ends_on: assert property (s_blank_over_tripped |=> !on_reg) // R8
        else $error("on-time not ended by trip");
    a_hold_untrip: assert property (on_reg && cmd_i && blk_reg == 8'h00 && !trip_i |=> on_reg || !cmd_i) // R8
        else $error("on-time ended without trip");
    a_step_timing: assert property (step_reg |-> act_run_reg == 32'(PEAK_CYC)) // R5
        else $error("peak phase length wrong");
    a_step_single: assert property (step_reg |=> !step_reg ##1 ref_sel_o || !cmd_i) // R6
        else $error("step not a single pulse");
    a_ref_hold: assert property (ph_reg == sphc_pkg::PH_HOLD && cmd_i |=> ref_o == $past(ref_mem_reg[1])) // R10
        else $error("hold reference not selected");
    a_restart_peak: assert property ($rose(cmd_i) |=> ph_reg == sphc_pkg::PH_PEAK ##1 ref_o == $past(ref_mem_reg[0])) // R15 R9
        else $error("activation did not start with peak");
    a_fault_reg: assert property (##1 ind_o.fault == $past(fault_i)) // R14 R4
        else $error("fault output not registered input");
    a_act_level: assert property (cmd_i && !flt_reg |=> ind_o.activity) // R2
        else $error("activity low while active");
    a_act_idle: assert property (!cmd_i |=> !ind_o.activity) // R2
        else $error("activity high while idle");
    a_blink_rate: assert property ($changed(blink_reg) && flt_reg && $past(flt_reg) |-> $past(blk_cnt_reg) == 32'(BLINK_HALF - 1)) // R3
        else $error("blink toggled off schedule");
    a_ack_drive: assert property (ist_reg == sphc_pkg::IS_ACKA |-> $past(shift_reg) == {I2C_ADDR, 1'b0}) // R1
        else $error("ack without own write address");
endmodule
`default_nettype wire

// file: tb/sphc_stage_model.sv
// behavioural power stage with current trip comparator
`timescale 1ns/1ps
`default_nettype none
module sphc_stage_model (
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       drive_i,
    input  wire logic       sleep_i,
    input  wire logic       ref_sel_i,
    input  wire logic [7:0] rise_pk_i,
    input  wire logic [7:0] rise_hd_i,
    input  wire logic       short_i,
    output logic            trip_o,
    output logic            fault_o
);
    // ------------------------------------------------------------
    // coil current ramps while driven, collapses when released
    // ------------------------------------------------------------
    logic [7:0] cur_reg;
    logic [7:0] cur_next;

    always_comb begin
        cur_next = 8'h00;
        if (drive_i && !sleep_i) begin
            cur_next = (cur_reg == 8'hff) ? 8'hff : cur_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cur_reg <= 8'h00;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // a zero rise time means the comparator is already tripped
    assign trip_o  = cur_reg >= (ref_sel_i ? rise_hd_i : rise_pk_i);
    assign fault_o = short_i;
endmodule
`default_nettype wire

// file: tb/sphc_chopper_bench.sv
// self-checking bench of the peak and hold chopper
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); end end
module sphc_chopper_bench;
    localparam int PK = 200;
    localparam int BH = 20;
    localparam int PW = 100;
    logic                clk_sys_i;
    logic                resetn_i;
    logic                cmd_i;
    logic                fault_i;
    logic                trip_i;
    logic                scl_i;
    logic                sda_i;
    logic                sda_o;
    logic                sda_oe_n_o;
    logic                drive_o;
    logic                sleep_o;
    logic [7:0]          ref_o;
    logic                ref_sel_o;
    logic                step_o;
    logic                blank_o;
    sphc_pkg::sphc_ind_t ind_o;
    logic                sda_drv;
    logic                short;
    logic [7:0]          dp;
    logic [7:0]          dh;
    logic [7:0]          pk_val;
    logic [7:0]          hd_val;
    logic [7:0]          exp_ref;
    int                  q_on[$];
    logic [7:0]          q_ref[$];
    int                  exp_len;
    int                  hi_cnt;
    int                  bl_cnt;
    int                  act_cnt;
    int                  err_total;
    int                  n_compared;
    int                  cyc;
    integer              seed = 32'h4d87;

    // ------------------------------------------------------------
    // clock, open-drain data line, design and far side
    // ------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    assign sda_i = sda_drv & (sda_oe_n_o | sda_o);

    sphc_chopper #(.PEAK_CYC(PK), .BLINK_HALF(BH), .PWM_CYC(PW)) dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cmd_i(cmd_i), .fault_i(fault_i), .trip_i(trip_i),
        .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .drive_o(drive_o),
        .sleep_o(sleep_o), .ref_o(ref_o), .ref_sel_o(ref_sel_o), .step_o(step_o), .blank_o(blank_o), .ind_o(ind_o));

    sphc_stage_model stage (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .drive_i(drive_o), .sleep_i(sleep_o),
        .ref_sel_i(ref_sel_o), .rise_pk_i(dp), .rise_hd_i(dh), .short_i(short), .trip_o(trip_i),
        .fault_o(fault_i));

    // ------------------------------------------------------------
    // monitor: on-time lengths and the peak to hold step
    // ------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (!resetn_i || !cmd_i) begin
            act_cnt = 0;
        end else begin
            if (step_o === 1'b1 && q_ref.size() > 0) begin
                exp_ref = q_ref.pop_front();
                `CHK(ref_o, exp_ref)
                `CHK(act_cnt, PK)
            end
            act_cnt++;
        end
        if (drive_o === 1'b1) begin
            hi_cnt++;
            if (blank_o === 1'b1) begin
                bl_cnt++;
            end
        end else begin
            if (hi_cnt > 0 && q_on.size() > 0) begin
                exp_len = q_on.pop_front();
                `CHK(hi_cnt, exp_len)
                `CHK(bl_cnt, sphc_pkg::BLANK_CYC)
            end
            hi_cnt = 0;
            bl_cnt = 0;
        end
    end

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task report_and_stop;
        $display("errors %0d compared %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    function automatic int on_len(input int d);
        return (d + 1 > sphc_pkg::BLANK_CYC) ? d + 1 : sphc_pkg::BLANK_CYC;
    endfunction

    task hp;
        repeat (4) @(negedge clk_sys_i);
    endtask

    task i2c_byte(input logic [7:0] b, input logic ack_exp);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = b[i]; hp(); scl_i = 1'b1; hp(); scl_i = 1'b0; hp();
        end
        sda_drv = 1'b1; hp(); scl_i = 1'b1; hp();
        `CHK(sda_i, ack_exp)
        scl_i = 1'b0; hp();
    endtask

    task i2c_start;
        sda_drv = 1'b1; scl_i = 1'b1; hp(); sda_drv = 1'b0; hp(); scl_i = 1'b0; hp();
    endtask

    task i2c_stop;
        sda_drv = 1'b0; hp(); scl_i = 1'b1; hp(); sda_drv = 1'b1; hp();
    endtask

    task act(input logic [7:0] d_pk, input logic [7:0] d_hd, input int n);
        dp = d_pk;
        dh = d_hd;
        for (int k = 0; k < n; k++) q_on.push_back(on_len(k * PW < PK ? d_pk : d_hd));
        q_ref.push_back(hd_val);
        cmd_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        `CHK(ref_o, pk_val)
        `CHK(ref_sel_o, 1'b0)
        `CHK(sleep_o, 1'b0)
        `CHK(ind_o.activity, 1'b1)
        repeat (n * PW - 8) @(negedge clk_sys_i);
        `CHK(ref_o, hd_val)
        `CHK(ref_sel_o, 1'b1)
        cmd_i = 1'b0;
        #1;
        `CHK(drive_o, 1'b0)
        `CHK(sleep_o, 1'b1)
        repeat (2) @(negedge clk_sys_i);
        `CHK(ind_o.activity, 1'b0)
        `CHK(q_on.size(), 0)
        `CHK(q_ref.size(), 0)
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        resetn_i = 1'b0; cmd_i = 1'b0; scl_i = 1'b1; sda_drv = 1'b1; short = 1'b0;
        dp = 8'h00; dh = 8'h00; hi_cnt = 0; act_cnt = 0; err_total = 0; n_compared = 0; cyc = 0;
        pk_val = sphc_pkg::REF_PEAK_RESET;
        hd_val = sphc_pkg::REF_HOLD_RESET;
        repeat (12) @(negedge clk_sys_i);
        `CHK(ref_o, pk_val)
        resetn_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        act(8'h00, 8'h4a, 3);
        act(8'h4b, 8'h4c + 8'({$random(seed)} % 10), 4);
        // abort mid on-time, then a fresh activation
        cmd_i = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        `CHK(drive_o, 1'b1)
        cmd_i = 1'b0;
        #1;
        `CHK(drive_o, 1'b0)
        repeat (2) @(negedge clk_sys_i);
        act(8'h4b, 8'h00, 3);
        // fault while active and while idle
        cmd_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        short = 1'b1;
        #1;
        `CHK(ind_o.fault, 1'b0)
        @(negedge clk_sys_i);
        `CHK(ind_o.fault, 1'b1)
        repeat (10) @(negedge clk_sys_i);
        `CHK(ind_o.activity, 1'b0)
        repeat (20) @(negedge clk_sys_i);
        `CHK(ind_o.activity, 1'b1)
        repeat (20) @(negedge clk_sys_i);
        `CHK(ind_o.activity, 1'b0)
        short = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        `CHK(ind_o.fault, 1'b0)
        `CHK(ind_o.activity, 1'b1)
        cmd_i = 1'b0;
        short = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        `CHK(ind_o.activity, 1'b0)
        `CHK(ind_o.fault, 1'b1)
        short = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        // reference rewrite over the two-wire port
        i2c_start();
        i2c_byte({sphc_pkg::I2C_ADDR_DEF ^ 7'h01, 1'b0}, 1'b1);
        i2c_stop();
        // read requests are not served and get no acknowledge
        i2c_start();
        i2c_byte({sphc_pkg::I2C_ADDR_DEF, 1'b1}, 1'b1);
        i2c_stop();
        pk_val = 8'($random(seed));
        hd_val = 8'($random(seed));
        i2c_start();
        i2c_byte({sphc_pkg::I2C_ADDR_DEF, 1'b0}, 1'b0);
        i2c_byte(sphc_pkg::REF_PEAK_IDX, 1'b0);
        i2c_byte(pk_val, 1'b0);
        i2c_byte(hd_val, 1'b0);
        // index past the hold entry is acknowledged and discarded
        i2c_byte(8'($random(seed)), 1'b0);
        i2c_stop();
        repeat (4) @(negedge clk_sys_i);
        act(8'h00, 8'h50, 3);
        report_and_stop();
    end
endmodule
`default_nettype wire
